// ### core/special_function_register_bank.sv
`timescale 1ns/1ps
module special_function_register_bank
    import sfr_bank_pkg::*;
#(
    parameter logic [15:0] MAIN_BASE = MAIN_BASE_DEFAULT
) (
    input wire logic i_mclk,                       // System clock
    input wire logic i_rst_b,                      // Power-on reset, active low
    input wire logic i_power_up_clear,             // Power-up clear, synchronous
    input wire logic i_rst_pin_reset,              // Reset seen on the reset/NMI pin in reset mode
    input wire sfr_bus_req_s i_bus,                // Peripheral bus byte access
    output logic [7:0] o_rdata,                    // Read data
    output logic o_rdata_valid,                    // Read data strobe
    input wire sfr_events_s i_events,              // Flag set events
    input wire logic i_wdt_interval_mode,          // Watchdog runs as interval timer
    input wire logic i_gie,                        // Global interrupt enable of the core
    input wire logic i_flash_violation_flag,       // Violation flag held in the flash module
    output sfr_irq_s o_irq,                        // Interrupt requests
    output sfr_module_en_s o_module_en,            // Serial module enables
    input wire logic i_erase_req,                  // Erase request pulse
    input wire erase_mode_e i_erase_mode,          // Erase kind
    input wire logic [15:0] i_erase_addr,          // Address inside the target segment
    output logic o_erase_go,                       // Erase accepted pulse
    output logic o_erase_reject,                   // Erase refused pulse
    output logic [15:0] o_erase_lo,                // First byte to erase
    output logic [15:0] o_erase_hi,                // Last byte to erase
    input wire logic i_prog_req,                   // Program write pulse
    input wire logic i_prog_word,                  // Word write when high, byte when low
    input wire logic [15:0] i_prog_addr,           // Program byte address
    input wire logic [15:0] i_prog_data,           // Program data
    output logic o_prog_go,                        // Program accepted pulse
    output logic o_prog_reject,                    // Program refused pulse
    output logic [15:0] o_prog_addr,               // Word address of the write
    output logic [15:0] o_prog_data,               // Data aligned to its lanes
    output logic [1:0] o_prog_be                   // Byte lanes written
);

    logic [7:0] irq_en_one_reg;
    logic [7:0] irq_en_one_next;
    logic [7:0] irq_en_two_reg;
    logic [7:0] irq_en_two_next;
    logic [7:0] flag_one_reg;
    logic [7:0] flag_one_next;
    logic [7:0] flag_two_reg;
    logic [7:0] flag_two_next;
    logic [7:0] mod_en_one_reg;
    logic [7:0] mod_en_one_next;
    logic [7:0] mod_en_two_reg;
    logic [7:0] mod_en_two_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rdata_valid_reg;
    logic rdata_valid_next;
    sfr_irq_s irq_reg;
    sfr_irq_s irq_next;
    logic wr_en;
    logic [7:0] set_one;
    logic [7:0] set_two;

    assign wr_en = i_bus.sel & i_bus.wr;

    // Hardware set events, gathered per flag byte
    always_comb begin
        set_one = 8'h00;
        set_two = 8'h00;
        set_one[BIT_WATCHDOG] = i_events.watchdog_overflow | i_events.key_violation;
        set_one[BIT_OSC_FAULT] = i_events.osc_fault;
        set_one[BIT_NMI] = i_events.nmi_event;
        set_one[BIT_SERIAL0_RX] = i_events.serial0_rx;
        set_one[BIT_SERIAL0_TX] = i_events.serial0_tx;
        set_two[BIT_SERIAL1_RX] = i_events.serial1_rx;
        set_two[BIT_SERIAL1_TX] = i_events.serial1_tx;
        set_two[BIT_BASIC_TIMER] = i_events.basic_timer;
    end

    // Next values: bus write, then pin reset, then power-up clear; hardware sets win last
    always_comb begin
        irq_en_one_next = irq_en_one_reg;
        irq_en_two_next = irq_en_two_reg;
        flag_one_next = flag_one_reg;
        flag_two_next = flag_two_reg;
        mod_en_one_next = mod_en_one_reg;
        mod_en_two_next = mod_en_two_reg;
        if (wr_en) begin
            if (i_bus.addr == ADDR_IRQ_EN_ONE) begin
                irq_en_one_next = i_bus.wdata;
            end else if (i_bus.addr == ADDR_IRQ_EN_TWO) begin
                irq_en_two_next = i_bus.wdata;
            end else if (i_bus.addr == ADDR_IRQ_FLAG_ONE) begin
                flag_one_next = i_bus.wdata;
            end else if (i_bus.addr == ADDR_IRQ_FLAG_TWO) begin
                flag_two_next = i_bus.wdata;
            end else if (i_bus.addr == ADDR_MOD_EN_ONE) begin
                mod_en_one_next = i_bus.wdata;
            end else if (i_bus.addr == ADDR_MOD_EN_TWO) begin
                mod_en_two_next = i_bus.wdata;
            end
        end
        // The watchdog flag survives power-up clear; of the two clear inputs only the pin reset clears it here
        if (i_rst_pin_reset) begin
            flag_one_next[BIT_WATCHDOG] = 1'b0;
        end
        if (i_power_up_clear) begin
            irq_en_one_next = CLR_VAL_ENABLE;
            irq_en_two_next = CLR_VAL_ENABLE;
            mod_en_one_next = CLR_VAL_ENABLE;
            mod_en_two_next = CLR_VAL_ENABLE;
            flag_one_next = (flag_one_next & ~CLR_MASK_FLAG_ONE) | CLR_VAL_FLAG_ONE;
            flag_two_next = (flag_two_next & ~CLR_MASK_FLAG_TWO) | CLR_VAL_FLAG_TWO;
        end
        // An event in the same cycle as a software clear is kept
        flag_one_next = flag_one_next | set_one;
        flag_two_next = flag_two_next | set_two;
        // Unassigned positions are forced to zero, so no storage is built for them
        irq_en_one_next = irq_en_one_next & MASK_IRQ_EN_ONE;
        irq_en_two_next = irq_en_two_next & MASK_IRQ_EN_TWO;
        flag_one_next = flag_one_next & MASK_IRQ_FLAG_ONE;
        flag_two_next = flag_two_next & MASK_IRQ_FLAG_TWO;
        mod_en_one_next = mod_en_one_next & MASK_MOD_EN_ONE;
        mod_en_two_next = mod_en_two_next & MASK_MOD_EN_TWO;
    end

    // Power-on reset gives every bit its value, including the parenthesised ones
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_en_one_reg <= POR_VAL_ENABLE;
            irq_en_two_reg <= POR_VAL_ENABLE;
            flag_one_reg <= POR_VAL_FLAG_ONE;
            flag_two_reg <= POR_VAL_FLAG_TWO;
            mod_en_one_reg <= POR_VAL_ENABLE;
            mod_en_two_reg <= POR_VAL_ENABLE;
        end else begin
            irq_en_one_reg <= irq_en_one_next;
            irq_en_two_reg <= irq_en_two_next;
            flag_one_reg <= flag_one_next;
            flag_two_reg <= flag_two_next;
            mod_en_one_reg <= mod_en_one_next;
            mod_en_two_reg <= mod_en_two_next;
        end
    end

    // Read mux; offsets 06h to 0Fh are unmapped and read zero
    always_comb begin
        rdata_next = 8'h00;
        rdata_valid_next = i_bus.sel & i_bus.rd;
        if (i_bus.sel & i_bus.rd) begin
            if (i_bus.addr == ADDR_IRQ_EN_ONE) begin
                rdata_next = irq_en_one_reg;
            end else if (i_bus.addr == ADDR_IRQ_EN_TWO) begin
                rdata_next = irq_en_two_reg;
            end else if (i_bus.addr == ADDR_IRQ_FLAG_ONE) begin
                rdata_next = flag_one_reg;
            end else if (i_bus.addr == ADDR_IRQ_FLAG_TWO) begin
                rdata_next = flag_two_reg;
            end else if (i_bus.addr == ADDR_MOD_EN_ONE) begin
                rdata_next = mod_en_one_reg;
            end else if (i_bus.addr == ADDR_MOD_EN_TWO) begin
                rdata_next = mod_en_two_reg;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_reg <= 8'h00;
            rdata_valid_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            rdata_valid_reg <= rdata_valid_next;
        end
    end

    // Interrupt requests; the first three ignore the global enable by design
    always_comb begin
        irq_next.nmi = irq_en_one_reg[BIT_NMI] & flag_one_reg[BIT_NMI];
        irq_next.osc_fault = irq_en_one_reg[BIT_OSC_FAULT] & flag_one_reg[BIT_OSC_FAULT];
        irq_next.flash_violation = irq_en_one_reg[BIT_FLASH_VIOL] & i_flash_violation_flag;
        irq_next.watchdog = i_gie & i_wdt_interval_mode
            & irq_en_one_reg[BIT_WATCHDOG] & flag_one_reg[BIT_WATCHDOG];
        irq_next.serial0_rx = i_gie & irq_en_one_reg[BIT_SERIAL0_RX] & flag_one_reg[BIT_SERIAL0_RX];
        irq_next.serial0_tx = i_gie & irq_en_one_reg[BIT_SERIAL0_TX] & flag_one_reg[BIT_SERIAL0_TX];
        irq_next.serial1_rx = i_gie & irq_en_two_reg[BIT_SERIAL1_RX] & flag_two_reg[BIT_SERIAL1_RX];
        irq_next.serial1_tx = i_gie & irq_en_two_reg[BIT_SERIAL1_TX] & flag_two_reg[BIT_SERIAL1_TX];
        irq_next.basic_timer = i_gie & irq_en_two_reg[BIT_BASIC_TIMER] & flag_two_reg[BIT_BASIC_TIMER];
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_reg <= '0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    // Flash erase range: segments are aligned, so masking the address finds the base
    logic in_info;
    logic in_main;
    logic erase_go_reg;
    logic erase_go_next;
    logic erase_reject_reg;
    logic erase_reject_next;
    logic [15:0] erase_lo_reg;
    logic [15:0] erase_lo_next;
    logic [15:0] erase_hi_reg;
    logic [15:0] erase_hi_next;

    assign in_info = (i_erase_addr >= INFO_BASE) && (i_erase_addr <= INFO_END);
    assign in_main = (i_erase_addr >= MAIN_BASE);

    always_comb begin
        erase_go_next = 1'b0;
        erase_reject_next = 1'b0;
        erase_lo_next = erase_lo_reg;
        erase_hi_next = erase_hi_reg;
        if (i_erase_req) begin
            case (i_erase_mode)
                ERASE_SEGMENT: begin
                    if (in_info) begin
                        erase_lo_next = i_erase_addr & ~(SEG_INFO_BYTES - 16'h0001);
                        erase_hi_next = erase_lo_next + (SEG_INFO_BYTES - 16'h0001);
                        erase_go_next = 1'b1;
                    end else if (in_main) begin
                        erase_lo_next = i_erase_addr & ~(SEG_MAIN_BYTES - 16'h0001);
                        erase_hi_next = erase_lo_next + (SEG_MAIN_BYTES - 16'h0001);
                        erase_go_next = 1'b1;
                    end else begin
                        erase_reject_next = 1'b1;
                    end
                end
                ERASE_MAIN_ALL: begin
                    erase_lo_next = MAIN_BASE;
                    erase_hi_next = MAIN_END;
                    erase_go_next = 1'b1;
                end
                ERASE_ALL: begin
                    // Info segments only go together with all of main, never alone as a pair
                    erase_lo_next = INFO_BASE;
                    erase_hi_next = MAIN_END;
                    erase_go_next = 1'b1;
                end
                default: begin
                    erase_reject_next = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            erase_go_reg <= 1'b0;
            erase_reject_reg <= 1'b0;
            erase_lo_reg <= 16'h0000;
            erase_hi_reg <= 16'h0000;
        end else begin
            erase_go_reg <= erase_go_next;
            erase_reject_reg <= erase_reject_next;
            erase_lo_reg <= erase_lo_next;
            erase_hi_reg <= erase_hi_next;
        end
    end

    // Program write: one byte or one aligned word per request, nothing wider
    logic prog_in_flash;
    logic prog_go_reg;
    logic prog_go_next;
    logic prog_reject_reg;
    logic prog_reject_next;
    logic [15:0] prog_addr_reg;
    logic [15:0] prog_addr_next;
    logic [15:0] prog_data_reg;
    logic [15:0] prog_data_next;
    logic [1:0] prog_be_reg;
    logic [1:0] prog_be_next;

    assign prog_in_flash = ((i_prog_addr >= INFO_BASE) && (i_prog_addr <= INFO_END)) || (i_prog_addr >= MAIN_BASE);

    always_comb begin
        prog_go_next = 1'b0;
        prog_reject_next = 1'b0;
        prog_addr_next = prog_addr_reg;
        prog_data_next = prog_data_reg;
        prog_be_next = prog_be_reg;
        if (i_prog_req) begin
            // A word at an odd address would span two words, so it is refused
            if (!prog_in_flash || (i_prog_word && i_prog_addr[0])) begin
                prog_reject_next = 1'b1;
            end else begin
                prog_go_next = 1'b1;
                prog_addr_next = {i_prog_addr[15:1], 1'b0};
                if (i_prog_word) begin
                    prog_data_next = i_prog_data;
                    prog_be_next = 2'b11;
                end else if (i_prog_addr[0]) begin
                    prog_data_next = {i_prog_data[7:0], 8'h00};
                    prog_be_next = 2'b10;
                end else begin
                    prog_data_next = {8'h00, i_prog_data[7:0]};
                    prog_be_next = 2'b01;
                end
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prog_go_reg <= 1'b0;
            prog_reject_reg <= 1'b0;
            prog_addr_reg <= 16'h0000;
            prog_data_reg <= 16'h0000;
            prog_be_reg <= 2'b00;
        end else begin
            prog_go_reg <= prog_go_next;
            prog_reject_reg <= prog_reject_next;
            prog_addr_reg <= prog_addr_next;
            prog_data_reg <= prog_data_next;
            prog_be_reg <= prog_be_next;
        end
    end

    // Outputs straight from flip-flops
    assign o_rdata = rdata_reg;
    assign o_rdata_valid = rdata_valid_reg;
    assign o_irq = irq_reg;
    assign o_module_en.serial0_async_tx_en = mod_en_one_reg[BIT_SERIAL0_TX];
    assign o_module_en.serial0_rx_or_sync_en = mod_en_one_reg[BIT_SERIAL0_RX];
    assign o_module_en.serial1_async_tx_en = mod_en_two_reg[BIT_SERIAL1_TX];
    assign o_module_en.serial1_rx_or_sync_en = mod_en_two_reg[BIT_SERIAL1_RX];
    assign o_erase_go = erase_go_reg;
    assign o_erase_reject = erase_reject_reg;
    assign o_erase_lo = erase_lo_reg;
    assign o_erase_hi = erase_hi_reg;
    assign o_prog_go = prog_go_reg;
    assign o_prog_reject = prog_reject_reg;
    assign o_prog_addr = prog_addr_reg;
    assign o_prog_data = prog_data_reg;
    assign o_prog_be = prog_be_reg;

endmodule

// ### include/sfr_bank_pkg.sv
package sfr_bank_pkg;

    // Byte offsets inside the special function register window
    localparam logic [3:0] ADDR_IRQ_EN_ONE = 4'h0;
    localparam logic [3:0] ADDR_IRQ_EN_TWO = 4'h1;
    localparam logic [3:0] ADDR_IRQ_FLAG_ONE = 4'h2;
    localparam logic [3:0] ADDR_IRQ_FLAG_TWO = 4'h3;
    localparam logic [3:0] ADDR_MOD_EN_ONE = 4'h4;
    localparam logic [3:0] ADDR_MOD_EN_TWO = 4'h5;

    // Bit positions, byte one
    localparam int BIT_WATCHDOG = 0;
    localparam int BIT_OSC_FAULT = 1;
    localparam int BIT_NMI = 4;
    localparam int BIT_FLASH_VIOL = 5;
    localparam int BIT_SERIAL0_RX = 6;
    localparam int BIT_SERIAL0_TX = 7;
    // Bit positions, byte two
    localparam int BIT_SERIAL1_RX = 4;
    localparam int BIT_SERIAL1_TX = 5;
    localparam int BIT_BASIC_TIMER = 7;

    // Implemented bits of each register; all other bits hold nothing
    localparam logic [7:0] MASK_IRQ_EN_ONE = 8'hf3;
    localparam logic [7:0] MASK_IRQ_EN_TWO = 8'hb0;
    localparam logic [7:0] MASK_IRQ_FLAG_ONE = 8'hd3;
    localparam logic [7:0] MASK_IRQ_FLAG_TWO = 8'hb0;
    localparam logic [7:0] MASK_MOD_EN_ONE = 8'hc0;
    localparam logic [7:0] MASK_MOD_EN_TWO = 8'h30;

    // Bits touched by power-up clear, and the values they take
    localparam logic [7:0] CLR_MASK_FLAG_ONE = 8'hd2;
    localparam logic [7:0] CLR_VAL_FLAG_ONE = 8'h82;
    localparam logic [7:0] CLR_MASK_FLAG_TWO = 8'h30;
    localparam logic [7:0] CLR_VAL_FLAG_TWO = 8'h20;
    localparam logic [7:0] CLR_VAL_ENABLE = 8'h00;
    // Values after power-on reset
    localparam logic [7:0] POR_VAL_FLAG_ONE = 8'h82;
    localparam logic [7:0] POR_VAL_FLAG_TWO = 8'h20;
    localparam logic [7:0] POR_VAL_ENABLE = 8'h00;

    // Flash organisation
    localparam logic [15:0] SEG_MAIN_BYTES = 16'h0200;
    localparam logic [15:0] SEG_INFO_BYTES = 16'h0080;
    localparam logic [15:0] INFO_BASE = 16'h1000;
    localparam logic [15:0] INFO_END = 16'h10ff;
    localparam logic [15:0] MAIN_END = 16'hffff;
    localparam logic [15:0] MAIN_BASE_DEFAULT = 16'h1100;

    typedef enum logic [2:0] {
        ERASE_SEGMENT = 3'b001,
        ERASE_MAIN_ALL = 3'b010,
        ERASE_ALL = 3'b100
    } erase_mode_e;

    typedef struct packed {
        logic sel;
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } sfr_bus_req_s;

    typedef struct packed {
        logic watchdog_overflow;
        logic key_violation;
        logic osc_fault;
        logic nmi_event;
        logic serial0_rx;
        logic serial0_tx;
        logic serial1_rx;
        logic serial1_tx;
        logic basic_timer;
    } sfr_events_s;

    typedef struct packed {
        logic watchdog;
        logic osc_fault;
        logic nmi;
        logic flash_violation;
        logic serial0_rx;
        logic serial0_tx;
        logic serial1_rx;
        logic serial1_tx;
        logic basic_timer;
    } sfr_irq_s;

    typedef struct packed {
        logic serial0_async_tx_en;
        logic serial0_rx_or_sync_en;
        logic serial1_async_tx_en;
        logic serial1_rx_or_sync_en;
    } sfr_module_en_s;

endpackage

// ### test/sfr_bank_asserts.sv
`timescale 1ns/1ps
// Port timing checks for the register bank
module sfr_bank_asserts
    import sfr_bank_pkg::*;
(
    input wire logic i_mclk, // Clock
    input wire logic i_rst_b, // Reset, low
    input wire sfr_bus_req_s i_bus, // Bus request
    input wire logic [7:0] o_rdata, // Read data
    input wire logic o_rdata_valid, // Read strobe
    input wire logic i_wdt_interval_mode, // Interval mode
    input wire logic i_gie, // Global enable
    input wire sfr_irq_s o_irq, // Requests
    input wire logic i_erase_req, // Erase request
    input wire logic o_erase_go, // Erase taken
    input wire logic o_erase_reject, // Erase refused
    input wire logic i_prog_req, // Program request
    input wire logic i_prog_word, // Word write
    input wire logic o_prog_go, // Program taken
    input wire logic o_prog_reject, // Program refused
    input wire logic [15:0] o_prog_addr, // Word address
    input wire logic [1:0] o_prog_be // Byte lanes
);
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);

    // Reads answer on the next cycle; without a read the data falls back to zero
    a_read_answer: assert property (i_bus.sel && i_bus.rd |=> o_rdata_valid)
        else $error("read not answered");
    a_idle_quiet: assert property (!(i_bus.sel && i_bus.rd) |=> !o_rdata_valid && o_rdata == 8'h00)
        else $error("stray read data");
    // Low nibble of the second bytes holds no storage
    a_unimpl_zero: assert property (o_rdata_valid && $past(i_bus.addr) inside {4'h1, 4'h3} |-> (o_rdata & 8'h4f) == 8'h00)
        else $error("unimplemented bit read as one");
    // Every request gets exactly one of accept or refuse, one cycle later
    a_erase_answer: assert property (i_erase_req |=> o_erase_go != o_erase_reject)
        else $error("erase not answered once");
    a_prog_answer: assert property (i_prog_req |=> o_prog_go != o_prog_reject)
        else $error("program not answered once");
    a_prog_lanes: assert property (o_prog_go |-> !o_prog_addr[0] && ($past(i_prog_word) ? o_prog_be == 2'h3 : $onehot(o_prog_be)))
        else $error("program lanes wrong");
    // Watchdog request needs interval mode; maskable ones need the global enable
    a_wdt_mode: assert property (!i_wdt_interval_mode |=> !o_irq.watchdog)
        else $error("watchdog request in reset mode");
    a_gie_mask: assert property (!i_gie |=> !(o_irq.watchdog || o_irq.serial0_rx || o_irq.serial0_tx || o_irq.serial1_rx || o_irq.serial1_tx || o_irq.basic_timer))
        else $error("maskable request without global enable");
    c_read: cover property (i_bus.sel && i_bus.rd ##1 o_rdata_valid);
    c_erase_rej: cover property (o_erase_reject);
    c_prog_word: cover property (o_prog_go && o_prog_be == 2'h3);
endmodule

// ### test/sfr_cpu_model.sv
`timescale 1ns/1ps
// Core side of the peripheral bus, one byte access at a time
module sfr_cpu_model
    import sfr_bank_pkg::*;
(
    input wire logic i_mclk, // Clock
    input wire logic [7:0] i_rdata, // Read data
    input wire logic i_rdata_valid, // Read strobe
    output sfr_bus_req_s o_bus // Bus request
);
    initial o_bus = '0;
    // Held across the taking edge; idle bus shows inverted leftovers so stale values never pass
    task automatic access(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge i_mclk);
        o_bus = '{sel: 1'h1, wr: w, rd: !w, addr: a, wdata: d};
        @(negedge i_mclk);
        o_bus = '{sel: 1'h0, wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~d};
        q = i_rdata_valid ? i_rdata : 8'hxx;
    endtask
endmodule

// ### test/special_function_register_bank_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module special_function_register_bank_tb_top
    import sfr_bank_pkg::*;
    ;
    logic mclk = 1'h0, rst_b = 1'h0, pwr_clr = 1'h0, pin_rst = 1'h0, wdt_int = 1'h0, gie = 1'h0;
    logic fviol = 1'h0, ereq = 1'h0, preq = 1'h0, pword = 1'h0, rvalid, ego, erej, pgo, prej;
    logic [15:0] eaddr = 16'h0000, paddr = 16'h0000, pdata = 16'h0000, elo, ehi, po_addr, po_data;
    logic [7:0] rdata, q;
    logic [1:0] pbe;
    erase_mode_e emode = ERASE_SEGMENT;
    sfr_bus_req_s bus;
    sfr_events_s ev = '0;
    sfr_irq_s irq;
    sfr_module_en_s men;
    int n_mismatch = 0, checks = 0, cyc = 0;

    special_function_register_bank u_dut (.i_mclk(mclk), .i_rst_b(rst_b), .i_power_up_clear(pwr_clr),
        .i_rst_pin_reset(pin_rst), .i_bus(bus), .o_rdata(rdata), .o_rdata_valid(rvalid), .i_events(ev),
        .i_wdt_interval_mode(wdt_int), .i_gie(gie), .i_flash_violation_flag(fviol), .o_irq(irq),
        .o_module_en(men), .i_erase_req(ereq), .i_erase_mode(emode), .i_erase_addr(eaddr), .o_erase_go(ego),
        .o_erase_reject(erej), .o_erase_lo(elo), .o_erase_hi(ehi), .i_prog_req(preq), .i_prog_word(pword),
        .i_prog_addr(paddr), .i_prog_data(pdata), .o_prog_go(pgo), .o_prog_reject(prej), .o_prog_addr(po_addr),
        .o_prog_data(po_data), .o_prog_be(pbe));
    sfr_cpu_model u_cpu (.i_mclk(mclk), .i_rdata(rdata), .i_rdata_valid(rvalid), .o_bus(bus));

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        u_cpu.access(1'h1, a, d, q);
    endtask
    task automatic rd(logic [3:0] a, logic [7:0] e);
        u_cpu.access(1'h0, a, 8'h00, q);
        `CHK(q, e)
    endtask
    // Offset 6 is the first unmapped one and must read zero
    task automatic rd_all(logic [7:0] e[7]);
        for (int i = 0; i < 7; i++) begin
            rd(i[3:0], e[i]);
        end
    endtask
    // Reset values, then all ones at offsets 0 to 6: only implemented bits stick
    task automatic t_regs();
        rd_all('{8'h00, 8'h00, 8'h82, 8'h20, 8'h00, 8'h00, 8'h00});
        for (int i = 0; i < 7; i++) begin
            wr(i[3:0], 8'hff);
        end
        rd_all('{8'hf3, 8'hb0, 8'hd3, 8'hb0, 8'hc0, 8'h30, 8'h00});
        `CHK(men, 4'hf)
        $display("test regs done");
    endtask
    // Power-up clear keeps the watchdog and timer flags; the pin reset clears the watchdog flag
    task automatic t_clear();
        pwr_clr = 1'h1;
        tick(1);
        pwr_clr = 1'h0;
        rd_all('{8'h00, 8'h00, 8'h83, 8'ha0, 8'h00, 8'h00, 8'h00});
        `CHK(men, 4'h0)
        pin_rst = 1'h1;
        tick(1);
        pin_rst = 1'h0;
        rd(4'h2, 8'h82);
        ev.watchdog_overflow = 1'h1;
        tick(1);
        ev = '0;
        rd(4'h2, 8'h83);
        wr(4'h2, 8'h82);
        rd(4'h2, 8'h82);
        ev.key_violation = 1'h1;
        tick(1);
        ev = '0;
        rd(4'h2, 8'h83);
        // Receive event in the cycle of a software clear: the set wins
        fork
            wr(4'h2, 8'h83);
            begin
                tick(1);
                ev.serial0_rx = 1'h1;
                tick(1);
                ev = '0;
            end
        join
        rd(4'h2, 8'hc3);
        $display("test clear done");
    endtask
    // Requests: order is watchdog, osc, nmi, flash, serial0 rx/tx, serial1 rx/tx, timer
    task automatic t_irq();
        wr(4'h0, 8'h13);
        ev.nmi_event = 1'h1;
        tick(1);
        ev = '0;
        tick(2);
        `CHK(irq, 9'h0c0)
        gie = 1'h1;
        wdt_int = 1'h1;
        tick(2);
        `CHK(irq, 9'h1c0)
        gie = 1'h0;
        fviol = 1'h1;
        wr(4'h0, 8'hb3);
        tick(2);
        `CHK(irq, 9'h0e0)
        gie = 1'h1;
        tick(2);
        `CHK(irq, 9'h1e8)
        wdt_int = 1'h0;
        tick(2);
        `CHK(irq, 9'h0e8)
        wr(4'h1, 8'hb0);
        tick(2);
        `CHK(irq, 9'h0eb)
        $display("test irq done");
    endtask
    // A refused erase leaves the previous range in place
    task automatic erase(erase_mode_e m, logic [15:0] a, logic ok, logic [15:0] lo, logic [15:0] hi);
        tick(1);
        ereq = 1'h1;
        emode = m;
        eaddr = a;
        tick(1);
        ereq = 1'h0;
        eaddr = ~a;
        `CHK({ego, erej}, {ok, ~ok})
        `CHK({elo, ehi}, {lo, hi})
    endtask
    task automatic t_erase();
        erase(ERASE_SEGMENT, 16'h1085, 1'h1, 16'h1080, 16'h10ff);
        erase(ERASE_SEGMENT, 16'h13fe, 1'h1, 16'h1200, 16'h13ff);
        erase(ERASE_MAIN_ALL, 16'h0000, 1'h1, 16'h1100, 16'hffff);
        erase(ERASE_ALL, 16'h0000, 1'h1, 16'h1000, 16'hffff);
        erase(ERASE_SEGMENT, 16'h0500, 1'h0, 16'h1000, 16'hffff);
        erase(erase_mode_e'(3'h3), 16'h1085, 1'h0, 16'h1000, 16'hffff);
        $display("test erase done");
    endtask
    task automatic prog(logic w, logic [15:0] a, logic [15:0] d, logic ok, logic [15:0] ea, logic [15:0] ed,
        logic [1:0] be);
        tick(1);
        preq = 1'h1;
        pword = w;
        paddr = a;
        pdata = d;
        tick(1);
        preq = 1'h0;
        `CHK({pgo, prej}, {ok, ~ok})
        `CHK({po_addr, po_data, pbe}, {ea, ed, be})
    endtask
    task automatic t_prog();
        prog(1'h0, 16'h1101, 16'h00ab, 1'h1, 16'h1100, 16'hab00, 2'h2);
        prog(1'h0, 16'h1100, 16'h00cd, 1'h1, 16'h1100, 16'h00cd, 2'h1);
        prog(1'h1, 16'h1102, 16'h1234, 1'h1, 16'h1102, 16'h1234, 2'h3);
        prog(1'h1, 16'h1103, 16'h5678, 1'h0, 16'h1102, 16'h1234, 2'h3);
        prog(1'h0, 16'h0300, 16'h00ee, 1'h0, 16'h1102, 16'h1234, 2'h3);
        $display("test prog done");
    endtask

    // Clock, and a ceiling well above the 120 or so cycles the tests need
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            test_done();
        end
    end
    initial begin
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        rst_b = 1'h1;
        t_regs();
        t_clear();
        t_irq();
        t_erase();
        t_prog();
        test_done();
    end
endmodule
bind special_function_register_bank sfr_bank_asserts u_chk (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_bus(i_bus),
    .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid), .i_wdt_interval_mode(i_wdt_interval_mode), .i_gie(i_gie),
    .o_irq(o_irq), .i_erase_req(i_erase_req), .o_erase_go(o_erase_go), .o_erase_reject(o_erase_reject),
    .i_prog_req(i_prog_req), .i_prog_word(i_prog_word), .o_prog_go(o_prog_go), .o_prog_reject(o_prog_reject),
    .o_prog_addr(o_prog_addr), .o_prog_be(o_prog_be));
